/* src/fdr_pkg.sv */
/*
 * fdr_pkg: shared constants for the floppy controller tape, status and rate register slice.
 * Assumes a 40 MHz system clock and an AHB-Lite register bus with 32-bit data.
 */
package fdr_pkg;
   // ------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [2:0] IDX_TAPE_MEDIA = 3'h3;
   localparam logic [2:0] IDX_STATUS_RATE = 3'h4;
   localparam logic [2:0] IDX_CONFIG_RATE = 3'h7;
   localparam int unsigned ADDR_LSB = 2;
   localparam int unsigned IDX_W = 3;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int unsigned TSEL_LSB = 0;
   localparam int unsigned DMAP_LSB = 2;
   localparam int unsigned MSEN_LSB = 6;
   localparam int unsigned RATE_LSB = 0;
   localparam int unsigned PRE_LSB = 2;
   localparam int unsigned MANUAL_POWER_DOWN_BIT = 6;
   localparam int unsigned SELF_CLEARING_SOFT_RESET_BIT = 7;

   // ------------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] RATE_RST = 2'h2;
   localparam logic [2:0] PRE_RST = 3'h0;
   localparam logic [1:0] TSEL_RST = 2'h0;
   localparam logic [1:0] DMAP_RST = 2'h0;
   localparam logic [7:0] PRECOMP_TRACK_RST = 8'h00;
   localparam logic [7:0] STATUS_IDLE = 8'h00;
   localparam logic [7:0] TAPE_UNDRIVEN_COMPAT = 8'hFC;
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h1;
   localparam logic [1:0] RATE_250K = 2'h2;
   localparam logic [1:0] RATE_1M = 2'h3;

   // precompensation delays in tenths of a nanosecond
   localparam logic [11:0] PRE_DEF_SLOW = 12'h4E2;   // 125.0
   localparam logic [11:0] PRE_DEF_FAST = 12'h1A1;   // 41.7
   localparam logic [11:0] PRE_41_7 = 12'h1A1;
   localparam logic [11:0] PRE_83_3 = 12'h341;
   localparam logic [11:0] PRE_125_0 = 12'h4E2;
   localparam logic [11:0] PRE_66_7 = 12'h29B;
   localparam logic [11:0] PRE_208_3 = 12'h823;
   localparam logic [11:0] PRE_250_0 = 12'h9C4;
   localparam logic [11:0] PRE_0_0 = 12'h000;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 25000;
   localparam int unsigned INIT_MAX_PS = 2500000;
   // longest time: rounded down
   localparam int unsigned INIT_CYCLES = INIT_MAX_PS / CLK_PERIOD_PS;
   localparam int unsigned INIT_CNT_W = 7;
endpackage

/* src/fdr_regs.sv */
/*
 * fdr_regs: tape/media/drive-map register, main handshake status and
 * rate/precompensation/power register of a floppy controller, as an AHB-Lite slave.
 * Assumes the command engine gives byte and command events as one-cycle pulses,
 * and the configuration register gives layout mode and drive-map enable as levels.
 */
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fdr_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [7:0] o_rd_undriven,
   // configuration levels
   input wire logic i_enhanced_mode,
   input wire logic i_drive_map_en,
   input wire logic i_dor_run,
   // command engine events and state
   input wire logic i_data_xfer,
   input wire logic i_core_ready,
   input wire logic i_dir_to_host,
   input wire logic i_non_dma_exec,
   input wire logic i_irq,
   input wire logic i_first_cmd_byte,
   input wire logic i_last_cmd_no_result,
   input wire logic i_last_result_read,
   input wire logic i_seek_issued,
   input wire logic [1:0] i_seek_drive,
   input wire logic i_sense_first_result,
   input wire logic [1:0] i_sense_drive,
   input wire logic i_cfg_track_wr,
   input wire logic [7:0] i_cfg_track,
   // drive pins
   input wire logic i_media_sense_hi,
   input wire logic i_media_sense_lo,
   input wire logic [3:0] i_log_drive_sel,
   input wire logic [3:0] i_log_motor,
   output logic o_phys_drive_sel_0,
   output logic o_phys_drive_sel_1,
   output logic o_phys_motor_0,
   output logic o_phys_motor_1,
   // controller control outputs
   output logic o_core_reset,
   output logic o_manual_power_down,
   output logic [3:0] o_tape_drive,
   output logic [1:0] o_data_rate,
   output logic [2:0] o_precomp_sel,
   output logic [11:0] o_precomp_delay,
   output logic [7:0] o_precomp_track
);

   // ------------------------------------------------------------------
   // functions
   // ------------------------------------------------------------------
   function automatic logic [3:0] fdr_onehot(input logic [1:0] idx);
      fdr_onehot = 4'h1 << idx;
   endfunction

   function automatic logic [11:0] fdr_precomp(input logic [2:0] sel, input logic [1:0] rate);
      unique case (sel)
         3'h0: fdr_precomp = (rate == fdr_pkg::RATE_1M) ?
                             fdr_pkg::PRE_DEF_FAST : fdr_pkg::PRE_DEF_SLOW;
         3'h1: fdr_precomp = fdr_pkg::PRE_41_7;
         3'h2: fdr_precomp = fdr_pkg::PRE_83_3;
         3'h3: fdr_precomp = fdr_pkg::PRE_125_0;
         3'h4: fdr_precomp = fdr_pkg::PRE_66_7;
         3'h5: fdr_precomp = fdr_pkg::PRE_208_3;
         3'h6: fdr_precomp = fdr_pkg::PRE_250_0;
         3'h7: fdr_precomp = fdr_pkg::PRE_0_0;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // bus address phase capture
   // ------------------------------------------------------------------
   logic wr_pend_q;
   logic [2:0] wr_idx_q;
   logic addr_ok;
   logic [2:0] addr_idx;
   logic rd_take;
   logic wr_tape;
   logic wr_rate;
   logic wr_cfg;
   logic [7:0] wbyte;

   // bits above the index and the two low address bits must be zero; unmapped reads give zero, writes drop
   assign addr_ok = i_hsel && i_htrans[1] && i_hready;
   assign addr_idx = i_haddr[fdr_pkg::ADDR_LSB +: fdr_pkg::IDX_W];
   assign rd_take = addr_ok && !i_hwrite;
   assign wbyte = i_hwdata[7:0];
   assign wr_tape = wr_pend_q && (wr_idx_q == fdr_pkg::IDX_TAPE_MEDIA);
   assign wr_rate = wr_pend_q && (wr_idx_q == fdr_pkg::IDX_STATUS_RATE);
   assign wr_cfg = wr_pend_q && (wr_idx_q == fdr_pkg::IDX_CONFIG_RATE);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 3'h0;
      end else begin
         wr_pend_q <= addr_ok && i_hwrite && (i_haddr[31:5] == 27'h0) &&
                      (i_haddr[1:0] == 2'h0);
         wr_idx_q <= addr_idx;
      end
   end

   // zero wait states: status is readable at any moment with no delay
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   // ------------------------------------------------------------------
   // rate, precompensation and power register
   // ------------------------------------------------------------------
   logic [1:0] rate_q;
   logic [2:0] pre_q;
   logic manual_power_down_q;
   logic self_clearing_soft_reset_q;
   logic soft_reset;

   // soft reset does not touch these fields; only the hardware reset does
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rate_q <= fdr_pkg::RATE_RST;
         pre_q <= fdr_pkg::PRE_RST;
      end else if (wr_rate) begin
         rate_q <= wbyte[fdr_pkg::RATE_LSB +: 2];
         pre_q <= wbyte[fdr_pkg::PRE_LSB +: 3];
      end else if (wr_cfg) begin
         rate_q <= wbyte[fdr_pkg::RATE_LSB +: 2];
      end
   end

   // self-clearing reset request, one cycle wide
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         self_clearing_soft_reset_q <= 1'b0;
      end else begin
         self_clearing_soft_reset_q <= wr_rate && wbyte[fdr_pkg::SELF_CLEARING_SOFT_RESET_BIT];
      end
   end

   assign soft_reset = self_clearing_soft_reset_q || !i_dor_run;

   // power down sticks until a hardware or soft reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         manual_power_down_q <= 1'b0;
      end else if (soft_reset) begin
         manual_power_down_q <= 1'b0;
      end else if (wr_rate && wbyte[fdr_pkg::MANUAL_POWER_DOWN_BIT]) begin
         manual_power_down_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // core reset and initialisation timer
   // ------------------------------------------------------------------
   logic core_rst_q;
   logic [fdr_pkg::INIT_CNT_W-1:0] init_cnt_q;
   logic init_done_q;
   logic init_done_prev_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         core_rst_q <= 1'b1;
      end else begin
         core_rst_q <= soft_reset || manual_power_down_q || (wr_rate && wbyte[fdr_pkg::MANUAL_POWER_DOWN_BIT]);
      end
   end

   // init runs after any reset or power-down recovery; kept at its worst-case length
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || core_rst_q) begin
         init_cnt_q <= '0;
         init_done_q <= 1'b0;
      end else if (!init_done_q) begin
         if (init_cnt_q == fdr_pkg::INIT_CNT_W'(fdr_pkg::INIT_CYCLES - 1)) begin
            init_done_q <= 1'b1;
         end else begin
            init_cnt_q <= init_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         init_done_prev_q <= 1'b0;
      end else begin
         init_done_prev_q <= init_done_q;
      end
   end

   // ------------------------------------------------------------------
   // main handshake status
   // ------------------------------------------------------------------
   logic host_req_q;
   logic cmd_busy_q;
   logic [3:0] drv_busy_q;
   logic [7:0] status_val;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || core_rst_q) begin
         host_req_q <= 1'b0;
      end else if (init_done_q && !init_done_prev_q) begin
         host_req_q <= 1'b1;
      end else if (i_non_dma_exec) begin
         host_req_q <= i_irq;
      end else if (i_data_xfer) begin
         host_req_q <= 1'b0;
      end else if (i_core_ready) begin
         host_req_q <= 1'b1;
      end
   end

   // set wins over clear when both arrive together
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || core_rst_q) begin
         cmd_busy_q <= 1'b0;
      end else if (i_first_cmd_byte) begin
         cmd_busy_q <= 1'b1;
      end else if (i_last_result_read || i_last_cmd_no_result) begin
         cmd_busy_q <= 1'b0;
      end
   end

   genvar gd;
   generate
      for (gd = 0; gd < 4; gd++) begin : g_drv
         always_ff @(posedge i_clk) begin
            if (!i_rst_n || core_rst_q) begin
               drv_busy_q[gd] <= 1'b0;
            end else if (i_seek_issued && (i_seek_drive == 2'(gd))) begin
               drv_busy_q[gd] <= 1'b1;
            end else if (i_sense_first_result && (i_sense_drive == 2'(gd))) begin
               drv_busy_q[gd] <= 1'b0;
            end
         end
      end
   endgenerate

   always_comb begin
      if (!init_done_q) begin
         status_val = fdr_pkg::STATUS_IDLE;
      end else begin
         status_val = {host_req_q,
                       i_dir_to_host && !core_rst_q,
                       i_non_dma_exec && !core_rst_q,
                       cmd_busy_q, drv_busy_q};
      end
   end

   // ------------------------------------------------------------------
   // tape, media and drive map register
   // ------------------------------------------------------------------
   logic [1:0] tsel_q;
   logic [1:0] dmap_q;
   logic [7:0] tape_val;
   logic [7:0] tape_undriven;

   // tape select survives soft reset; only the hardware reset clears it
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tsel_q <= fdr_pkg::TSEL_RST;
         dmap_q <= fdr_pkg::DMAP_RST;
      end else if (wr_tape) begin
         tsel_q <= wbyte[fdr_pkg::TSEL_LSB +: 2];
         if (i_enhanced_mode) begin
            dmap_q <= wbyte[fdr_pkg::DMAP_LSB +: 2];
         end
      end
   end

   always_comb begin
      if (i_enhanced_mode) begin
         tape_val = {i_media_sense_hi, i_media_sense_lo,
                     2'h0,
                     dmap_q, tsel_q};
         tape_undriven = 8'h00;
      end else begin
         tape_val = {6'h00, tsel_q};
         tape_undriven = fdr_pkg::TAPE_UNDRIVEN_COMPAT;
      end
   end

   // drive 0 can never be the tape drive
   assign o_tape_drive = (tsel_q == 2'h0) ? 4'h0 : fdr_onehot(tsel_q);

   // ------------------------------------------------------------------
   // read data, registered in the address phase
   // ------------------------------------------------------------------
   logic [7:0] rd_q;
   logic [7:0] undriven_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_q <= 8'h00;
         undriven_q <= 8'h00;
      end else if (rd_take) begin
         rd_q <= 8'h00;
         undriven_q <= 8'h00;
         if (i_haddr[31:5] == 27'h0 && i_haddr[1:0] == 2'h0) begin
            if (addr_idx == fdr_pkg::IDX_TAPE_MEDIA) begin
               rd_q <= tape_val;
               undriven_q <= tape_undriven;
            end else if (addr_idx == fdr_pkg::IDX_STATUS_RATE) begin
               rd_q <= status_val;
            end
         end
      end
   end

   assign o_hrdata = {24'h0, rd_q};
   assign o_rd_undriven = undriven_q;

   // ------------------------------------------------------------------
   // physical drive pin mapping
   // ------------------------------------------------------------------
   logic [1:0] map_code;

   assign map_code = i_drive_map_en ? dmap_q : 2'h0;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_phys_drive_sel_0 <= 1'b0;
         o_phys_drive_sel_1 <= 1'b0;
         o_phys_motor_0 <= 1'b0;
         o_phys_motor_1 <= 1'b0;
      end else begin
         unique case (map_code)
            2'h0: begin
               o_phys_drive_sel_0 <= i_log_drive_sel[0];
               o_phys_drive_sel_1 <= i_log_drive_sel[1];
               o_phys_motor_0 <= i_log_motor[0];
               o_phys_motor_1 <= i_log_motor[1];
            end
            2'h1: begin
               o_phys_drive_sel_0 <= i_log_drive_sel[1];
               o_phys_drive_sel_1 <= i_log_drive_sel[0];
               o_phys_motor_0 <= i_log_motor[1];
               o_phys_motor_1 <= i_log_motor[0];
            end
            2'h2, 2'h3: begin
               o_phys_drive_sel_0 <= i_log_drive_sel[map_code];
               o_phys_drive_sel_1 <= i_log_drive_sel[1];
               o_phys_motor_0 <= i_log_motor[map_code];
               o_phys_motor_1 <= i_log_motor[1];
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // precompensation track and outputs
   // ------------------------------------------------------------------
   logic [7:0] pre_track_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pre_track_q <= fdr_pkg::PRECOMP_TRACK_RST;
      end else if (i_cfg_track_wr) begin
         pre_track_q <= i_cfg_track;
      end
   end

   assign o_precomp_track = pre_track_q;
   assign o_core_reset = core_rst_q;
   assign o_manual_power_down = manual_power_down_q;
   assign o_data_rate = rate_q;
   assign o_precomp_sel = pre_q;
   assign o_precomp_delay = fdr_precomp(pre_q, rate_q);

endmodule // fdr_regs

/* dv/fdr_regs_sva.sv */
/*
 * fdr_regs_sva: bus, pin-map and control-output properties of the register slice.
 * Assumes a bind onto fdr_regs and byte addresses 0x0C, 0x10 and 0x1C.
 */
`timescale 1ns/1ps
module fdr_regs_sva (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // bus
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [7:0] o_rd_undriven,
   // configuration and pins
   input wire logic i_enhanced_mode,
   input wire logic i_drive_map_en,
   input wire logic i_dor_run,
   input wire logic i_media_sense_hi,
   input wire logic i_media_sense_lo,
   input wire logic [3:0] i_log_drive_sel,
   input wire logic o_phys_drive_sel_0,
   input wire logic o_phys_drive_sel_1,
   // control outputs
   input wire logic o_core_reset,
   input wire logic o_manual_power_down,
   input wire logic [3:0] o_tape_drive,
   input wire logic [1:0] o_data_rate,
   input wire logic [2:0] o_precomp_sel,
   input wire logic [11:0] o_precomp_delay,
   input wire logic [7:0] o_precomp_track
);
   // ---------------------------------------------------------------
   // address phases taken by the slave
   // ---------------------------------------------------------------
   wire logic tk = i_hsel && i_htrans[1] && i_hready;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   bus_ready_a: assert property (
      o_hreadyout && !o_hresp) else $error("status read stalled or errored");
   map_ident_a: assert property (
      !i_drive_map_en |=> o_phys_drive_sel_0 == $past(i_log_drive_sel[0])
      && o_phys_drive_sel_1 == $past(i_log_drive_sel[1])) else $error("unmapped pins not identity");
   tape_onehot_a: assert property (
      $onehot0(o_tape_drive) && !o_tape_drive[0]) else $error("bad tape drive assignment");
   run_low_a: assert property (
      !i_dor_run |=> o_core_reset) else $error("core not held while run bit low");
   pdown_core_a: assert property (
      $rose(o_manual_power_down) |-> o_core_reset) else $error("power down without core reset");
   rate_write_a: assert property (
      tk && i_hwrite && i_haddr == 32'h10 |=> ##1 o_data_rate == $past(i_hwdata[1:0])
      && o_precomp_sel == $past(i_hwdata[4:2])) else $error("rate register write lost");
   ccr_write_a: assert property (
      tk && i_hwrite && i_haddr == 32'h1C |=> ##1 o_data_rate == $past(i_hwdata[1:0]))
      else $error("config rate write lost");
   hw_reset_a: assert property (
      $rose(i_rst_n) |-> o_data_rate == 2'h2 && o_precomp_sel == 3'h0
      && o_precomp_track == 8'h00 && !o_manual_power_down) else $error("bad reset values");
   compat_mask_a: assert property (
      tk && !i_hwrite && i_haddr == 32'h0C && !i_enhanced_mode |=> o_rd_undriven == 8'hFC
      && o_hrdata[31:2] == 30'h0) else $error("compatible read drives upper bits");
   enh_read_a: assert property (
      tk && !i_hwrite && i_haddr == 32'h0C && i_enhanced_mode |=> o_hrdata[7:4] ==
      {$past(i_media_sense_hi), $past(i_media_sense_lo), 2'b00}) else $error("media bits wrong");
   precomp_off_a: assert property (
      o_precomp_sel == 3'h7 |-> o_precomp_delay == 12'h000) else $error("precomp not off");
   fast_default_a: assert property (
      o_precomp_sel == 3'h0 && o_data_rate == 2'h3 |-> o_precomp_delay == 12'h1A1)
      else $error("fast default precomp wrong");
endmodule // fdr_regs_sva

bind fdr_regs fdr_regs_sva fdr_regs_sva_i (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
   .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .o_rd_undriven,
   .i_enhanced_mode, .i_drive_map_en, .i_dor_run, .i_media_sense_hi, .i_media_sense_lo,
   .i_log_drive_sel, .o_phys_drive_sel_0, .o_phys_drive_sel_1, .o_core_reset,
   .o_manual_power_down, .o_tape_drive, .o_data_rate, .o_precomp_sel, .o_precomp_delay,
   .o_precomp_track);

/* dv/fdr_host.sv */
/*
 * fdr_host: host processor model, an AHB-Lite master doing single word transfers.
 * Assumes one slave whose hreadyout is the bus hready; callers enter xfer just after a rising edge.
 */
`timescale 1ns/1ps
module fdr_host (
   // bus
   input wire logic i_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata,
   // completed reads
   output logic [31:0] o_rd_data,
   output int o_rd_cnt
);
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = 3'h2;
      o_hwdata = 32'hA5A5_A5A5;
      o_rd_data = 32'h0;
      o_rd_cnt = 0;
   end

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      o_hsel <= 1'b1;
      o_haddr <= a;
      o_hwrite <= w;
      o_htrans <= 2'h2;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      o_htrans <= 2'h0;
      o_hwdata <= d;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      // a released data bus shows the inverse so a stale copy cannot pass
      o_hwdata <= ~d;
      if (!w) begin
         o_rd_data <= i_hrdata;
         o_rd_cnt <= o_rd_cnt + 1;
      end
   endtask
endmodule // fdr_host

/* dv/testbench.sv */
/*
 * testbench: drives the register slice through the host model and checks reads and pins.
 * Assumes fdr_host and the bound checker; reads are scored from a queue of expected values.
 */
`timescale 1ns/1ps
module testbench;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_hsel, i_hwrite, o_hreadyout, o_hresp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, rd_data, r;
   logic [1:0] i_htrans, o_data_rate, i_seek_drive = 2'h0, i_sense_drive = 2'h0;
   logic [2:0] i_hsize, o_precomp_sel;
   logic i_enhanced_mode = 1'b0, i_drive_map_en = 1'b0, i_dor_run = 1'b1, i_dir_to_host = 1'b0;
   logic i_non_dma_exec = 1'b0, i_irq = 1'b0, i_media_sense_hi = 1'b0, i_media_sense_lo = 1'b0;
   logic [7:0] i_cfg_track = 8'h00, o_rd_undriven, o_precomp_track, ev = 8'h00;
   logic [3:0] i_log_drive_sel = 4'h0, i_log_motor = 4'h0, o_tape_drive;
   logic o_phys_drive_sel_0, o_phys_drive_sel_1, o_phys_motor_0, o_phys_motor_1;
   logic o_core_reset, o_manual_power_down;
   logic [11:0] o_precomp_delay;
   wire logic i_data_xfer, i_core_ready, i_first_cmd_byte, i_last_cmd_no_result;
   wire logic i_last_result_read, i_seek_issued, i_sense_first_result, i_cfg_track_wr;
   int failures = 0, checked = 0, seed = 85537, rd_cnt, e;
   int dly[8] = '{0, 417, 833, 1250, 667, 2083, 2500, 0};
   logic [31:0] exp_q[$];
   assign {i_cfg_track_wr, i_sense_first_result, i_seek_issued, i_last_result_read,
      i_last_cmd_no_result, i_first_cmd_byte, i_core_ready, i_data_xfer} = ev;

   always #12.5 i_clk = ~i_clk;

   fdr_host fdr_host_i (.i_clk, .i_hready(o_hreadyout), .i_hrdata(o_hrdata), .o_hsel(i_hsel),
      .o_haddr(i_haddr), .o_htrans(i_htrans), .o_hwrite(i_hwrite), .o_hsize(i_hsize),
      .o_hwdata(i_hwdata), .o_rd_data(rd_data), .o_rd_cnt(rd_cnt));
   fdr_regs fdr_regs_i (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
      .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .o_rd_undriven,
      .i_enhanced_mode, .i_drive_map_en, .i_dor_run, .i_data_xfer, .i_core_ready, .i_dir_to_host,
      .i_non_dma_exec, .i_irq, .i_first_cmd_byte, .i_last_cmd_no_result, .i_last_result_read,
      .i_seek_issued, .i_seek_drive, .i_sense_first_result, .i_sense_drive, .i_cfg_track_wr,
      .i_cfg_track, .i_media_sense_hi, .i_media_sense_lo, .i_log_drive_sel, .i_log_motor,
      .o_phys_drive_sel_0, .o_phys_drive_sel_1, .o_phys_motor_0, .o_phys_motor_1, .o_core_reset,
      .o_manual_power_down, .o_tape_drive, .o_data_rate, .o_precomp_sel, .o_precomp_delay,
      .o_precomp_track);

   // ---------------------------------------------------------------
   // checking and bus helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      exp_q.push_back(x);
      fdr_host_i.xfer(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      fdr_host_i.xfer(1'b1, a, d);
   endtask
   // one-cycle event, then a spare edge so back-to-back pulses never collide
   task automatic pulse(input int b);
      ev <= 8'(1 << b);
      @(posedge i_clk);
      ev <= 8'h00;
      @(posedge i_clk);
   endtask
   task automatic summarize;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(rd_cnt) #1 if (exp_q.size() > 0) chk(rd_data, exp_q.pop_front());

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd(32'h10, 32'h00);
      @(negedge i_clk);
      chk(32'({o_data_rate, o_precomp_sel}), 32'h10);
      chk(32'(o_precomp_track), 32'h0);
      repeat (105) @(posedge i_clk);
      rd(32'h10, 32'h80);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         r = $random(seed);
         wr(32'h0C, {r[31:2], 2'(c)});
         rd(32'h0C, 32'(c));
         @(negedge i_clk);
         chk(32'(o_tape_drive), c == 0 ? 32'h0 : 32'h1 << c);
         @(posedge i_clk);
      end
      i_enhanced_mode <= 1'b1;
      i_drive_map_en <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         r = $random(seed);
         {i_media_sense_hi, i_media_sense_lo} <= 2'(m + 1);
         i_log_drive_sel <= r[3:0];
         i_log_motor <= r[7:4];
         wr(32'h0C, 32'h30 | 32'(m << 2) | 32'(r[9:8]));
         rd(32'h0C, {24'h0, 2'(m + 1), 2'b00, 2'(m), r[9:8]});
         @(negedge i_clk);
         chk({28'h0, o_phys_motor_1, o_phys_motor_0, o_phys_drive_sel_1, o_phys_drive_sel_0},
            {28'h0, m == 1 ? r[4] : r[5], r[4 + m], m == 1 ? r[0] : r[1], r[m]});
         @(posedge i_clk);
      end
      i_drive_map_en <= 1'b0;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk({30'h0, o_phys_drive_sel_1, o_phys_drive_sel_0}, {30'h0, r[1:0]});
      @(posedge i_clk);
      $display("test tape done");
      pulse(2);
      rd(32'h10, 32'h90);
      pulse(0);
      rd(32'h10, 32'h10);
      pulse(1);
      rd(32'h10, 32'h90);
      for (int d = 0; d < 4; d++) begin
         i_seek_drive <= 2'(d);
         i_sense_drive <= 2'(d);
         pulse(5);
         rd(32'h10, 32'h90 | 32'(1 << d));
         pulse(6);
         rd(32'h10, 32'h90);
      end
      pulse(4);
      rd(32'h10, 32'h80);
      pulse(2);
      pulse(3);
      rd(32'h10, 32'h80);
      i_dir_to_host <= 1'b1;
      @(posedge i_clk);
      rd(32'h10, 32'hC0);
      i_non_dma_exec <= 1'b1;
      @(posedge i_clk);
      rd(32'h10, 32'h60);
      i_irq <= 1'b1;
      @(posedge i_clk);
      rd(32'h10, 32'hE0);
      {i_irq, i_non_dma_exec, i_dir_to_host} <= 3'h0;
      $display("test status done");
      for (int q = 0; q < 10; q++) begin
         r = $random(seed);
         r[1:0] = q < 8 ? 2'(q + 3) : 2'(q);
         wr(32'h10, {r[31:8], 3'b001, 3'(q % 8), r[1:0]});
         @(negedge i_clk);
         e = q % 8 == 0 ? (r[1:0] == 2'h3 ? 417 : 1250) : dly[q % 8];
         chk(32'({o_data_rate, o_precomp_sel}), 32'({r[1:0], 3'(q % 8)}));
         chk(32'(o_precomp_delay), 32'(e));
         @(posedge i_clk);
      end
      wr(32'h1C, {r[31:2], 2'h3});
      wr(32'h18, r);
      rd(32'h18, 32'h0);
      @(negedge i_clk);
      chk(32'(o_data_rate), 32'h3);
      @(posedge i_clk);
      wr(32'h10, 32'h8D);
      repeat (3) @(posedge i_clk);
      rd(32'h10, 32'h00);
      @(negedge i_clk);
      chk(32'({o_data_rate, o_precomp_sel}), 32'h0B);
      repeat (105) @(posedge i_clk);
      rd(32'h10, 32'h80);
      wr(32'h10, 32'h4D);
      repeat (3) @(posedge i_clk);
      rd(32'h10, 32'h00);
      @(negedge i_clk);
      chk(32'({o_manual_power_down, o_core_reset}), 32'h3);
      repeat (110) @(posedge i_clk);
      rd(32'h10, 32'h00);
      i_dor_run <= 1'b0;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      chk(32'({o_manual_power_down, o_core_reset}), 32'h1);
      @(posedge i_clk);
      i_dor_run <= 1'b1;
      repeat (105) @(posedge i_clk);
      rd(32'h10, 32'h80);
      i_cfg_track <= r[7:0];
      pulse(7);
      @(negedge i_clk);
      chk(32'(o_precomp_track), 32'(r[7:0]));
      $display("test rate done");
      summarize();
   end

   initial begin
      repeat (3000) @(posedge i_clk);
      failures++;
      summarize();
   end
endmodule // testbench
